// [rdc_pkg.sv]
// Purpose: shared constants for the relay driver control die logic
// Assumes: 100 MHz core clock
// Notes:   control byte and status byte field positions, mode codes, watchdog timing
package rdc_pkg;
    // control byte fields
    localparam int CTL_SLEW_HI   = 7;
    localparam int CTL_SLEW_LO   = 6;
    localparam int CTL_PU_REL    = 5;
    localparam int CTL_SW3       = 4;
    localparam int CTL_SW2       = 3;
    localparam int CTL_SW1       = 2;
    localparam int CTL_OP_HI     = 1;
    localparam int CTL_OP_LO     = 0;
    // status byte fields
    localparam int STS_INTSRC    = 7;
    localparam int STS_BUS       = 6;
    localparam int STS_HIGH_V    = 5;
    localparam int STS_LOW_V     = 4;
    localparam int STS_REG_HEAT  = 3;
    localparam int STS_SW_HEAT   = 2;
    localparam int STS_WAKE2     = 1;
    localparam int STS_WAKE1     = 0;
    // reset values
    localparam logic [7:0] CTL_RESET     = 8'h03;
    localparam logic [1:0] SLEW_RESET    = 2'h0;
    // op state select codes
    localparam logic [1:0] OP_SLEEP      = 2'h0;
    localparam logic [1:0] OP_STOP       = 2'h1;
    localparam logic [1:0] OP_WD_CLEAR   = 2'h2;
    localparam logic [1:0] OP_RUN        = 2'h3;
    // slew codes
    localparam logic [1:0] SLEW_20K      = 2'h0;
    localparam logic [1:0] SLEW_10K      = 2'h1;
    localparam logic [1:0] SLEW_100K     = 2'h2;
    localparam logic [1:0] SLEW_LOWPOWER = 2'h3;
    // spi framing
    localparam int SPI_BITS          = 8;
    // timing
    localparam int CLK_HZ            = 100_000_000;
    localparam int WD_TIMEOUT_MS     = 150;
    localparam int WD_TIMEOUT_CYC    = WD_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WD_SLOPE_UMS_KOHM = 991;  // 0.991 ms per kohm, in microseconds
    localparam int WD_OFFSET_US      = 648;  // 0.648 ms
    localparam int WAKE_FILTER_US    = 50;
    localparam int WAKE_FILTER_CYC   = WAKE_FILTER_US * (CLK_HZ / 1_000_000);
endpackage

// [rdc_spi_slave.sv]
// Purpose: one-byte spi slave sampled in the core clock domain
// Assumes: serial clock far slower than core clock; mode: shift on rise, sample on fall
// Notes:   commits only when exactly eight sample edges were seen
`timescale 1ns/1ns
module rdc_spi_slave (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // pins
    input  wire logic       sel_n_i,
    input  wire logic       serial_clock_in_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    // core side
    input  wire logic [7:0] status_i,
    output logic [7:0]      rx_byte_o,
    output logic            rx_valid_o,
    output logic            frame_start_o
);
    logic [1:0] sel_sync_q;
    logic [1:0] sck_sync_q;
    logic [1:0] mosi_sync_q;
    logic       sel_last_q;
    logic       sck_last_q;
    logic [7:0] rx_sr_q;
    logic [7:0] tx_sr_q;
    logic [3:0] edge_cnt_q;
    logic       sel_fall;
    logic       sel_rise;
    logic       sck_rise;
    logic       sck_fall;

    // two-stage synchronisers for all three pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_sync_q  <= 2'h3;
            sck_sync_q  <= 2'h0;
            mosi_sync_q <= 2'h0;
            sel_last_q  <= 1'b1;
            sck_last_q  <= 1'b0;
        end else begin
            sel_sync_q  <= {sel_sync_q[0], sel_n_i};
            sck_sync_q  <= {sck_sync_q[0], serial_clock_in_i};
            mosi_sync_q <= {mosi_sync_q[0], mosi_i};
            sel_last_q  <= sel_sync_q[1];
            sck_last_q  <= sck_sync_q[1];
        end
    end

    assign sel_fall = sel_last_q & ~sel_sync_q[1];
    assign sel_rise = ~sel_last_q & sel_sync_q[1];
    assign sck_rise = ~sel_sync_q[1] & ~sck_last_q & sck_sync_q[1];
    assign sck_fall = ~sel_sync_q[1] & sck_last_q & ~sck_sync_q[1];

    // shift registers and edge counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sr_q    <= 8'h00;
            tx_sr_q    <= 8'h00;
            edge_cnt_q <= 4'h0;
            miso_o     <= 1'b0;
        end else if (sel_fall) begin
            tx_sr_q    <= {status_i[6:0], 1'b0};
            miso_o     <= status_i[7];
            edge_cnt_q <= 4'h0;
        end else begin
            if (sck_rise && edge_cnt_q != 4'h0) begin
                miso_o  <= tx_sr_q[7];
                tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            end
            if (sck_fall) begin
                rx_sr_q <= {rx_sr_q[6:0], mosi_sync_q[1]};
                // saturate so that extra edges still invalidate the frame
                if (edge_cnt_q != 4'hF) begin
                    edge_cnt_q <= edge_cnt_q + 4'h1;
                end
            end
        end
    end

    // output enable and commit strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miso_oe_o     <= 1'b0;
            rx_valid_o    <= 1'b0;
            rx_byte_o     <= 8'h00;
            frame_start_o <= 1'b0;
        end else begin
            frame_start_o <= sel_fall;
            if (sel_fall) begin
                miso_oe_o <= 1'b1;
            end else if (sel_rise) begin
                miso_oe_o <= 1'b0;
            end
            rx_valid_o <= sel_rise && edge_cnt_q == 4'(rdc_pkg::SPI_BITS);
            if (sel_rise) begin
                rx_byte_o <= rx_sr_q;
            end
        end
    end
endmodule

// [rdc_wake_filter.sv]
// Purpose: lin bus wake detector: long dominant then rising edge
// Assumes: bus level already synchronised to clk_i
// Notes:   counter saturates so long dominant levels stay qualified
`timescale 1ns/1ns
module rdc_wake_filter (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic arm_i,
    input  wire logic bus_level_i,
    // result
    output logic      wake_o
);
    localparam int CW = $clog2(rdc_pkg::WAKE_FILTER_CYC + 1);
    logic [CW-1:0] dom_cnt_q;
    logic          qualified_q;
    logic          level_last_q;

    // measure dominant length, fire on the following rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i || !arm_i) begin
            dom_cnt_q    <= '0;
            qualified_q  <= 1'b0;
            level_last_q <= 1'b1;
            wake_o       <= 1'b0;
        end else begin
            level_last_q <= bus_level_i;
            wake_o       <= 1'b0;
            if (!bus_level_i) begin
                if (dom_cnt_q == CW'(rdc_pkg::WAKE_FILTER_CYC)) begin
                    qualified_q <= 1'b1;
                end else begin
                    dom_cnt_q <= dom_cnt_q + 1'b1;
                end
            end else begin
                dom_cnt_q   <= '0;
                qualified_q <= 1'b0;
                wake_o      <= qualified_q & ~level_last_q;
            end
        end
    end
endmodule

// [rdc_control.sv]
// Purpose: control logic of the relay driver companion die
// Assumes: pins and analog indications arrive asynchronously to clk_i
// Notes:   spi slave, window watchdog, lin phy control, switch latch-off
//
// Summary of operation
// - any switch overheat turns all three switches off, latched, and sets thermal flag
// - switches are forced off in sleep or stop
// - slew setting comes from two control bits, reset gives 20 kbit/s
// - lin transmitter enabled only in normal and normal request states
// - lin driver fault shuts transmitter and sets bus fault flag
// - pull-up release bit of the low-power sequence disconnects pull-up there
// - transmit low drives bus dominant, high leaves it recessive
// - transmit input is treated as high when undriven
// - receive output follows bus level
// - in stop, qualified dominant pulse then rise raises wake interrupt and flag
// - in sleep, the same pulse wakes the system through reset and sets flag
// - in run, watchdog clears are accepted only inside the open window
// - clear in closed window or no clear by window end resets the device
// - first clear in normal request has no closed window, 150 ms limit
// - config pin open gives 150 ms period, grounded disables watchdog
// - resistor period is 0.991 ms per kohm plus 0.648 ms, as parameter
// - each spi frame is one byte each way
// - select fall starts frame, enables miso, captures status
// - data shifts out on clock rise and is sampled on clock fall
// - frame valid only with exactly eight sample edges
// - select rise commits control byte, miso released while select high
// - regulator heat gives prewarning flag with interrupt, then later shutdown
// - state bits: 00 sleep, 01 stop, 10 watchdog clear, 11 run
// - slew bits: 00 20k, 01 10k, 10 100k, 11 low-power request
// - sleep or stop entered only after the command byte arrives twice
// - bus flag clears on read while set; transmitter returns once fault gone and flag read
`timescale 1ns/1ns
module rdc_control #(
    parameter int WD_PERIOD_CYC = rdc_pkg::WD_TIMEOUT_CYC,  // resistor-set period
    parameter int WD_NREQ_CYC   = rdc_pkg::WD_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // spi pins
    input  wire logic sel_n_i,
    input  wire logic serial_clock_in_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    output logic      miso_oe_o,
    // lin phy
    input  wire logic txd_i,
    input  wire logic txd_oe_i,
    input  wire logic lin_bus_i,
    input  wire logic lin_fault_i,
    output logic      lin_drive_dom_o,
    output logic      rxd_o,
    output logic      lin_tx_en_o,
    output logic [1:0] bus_slew_select_o,
    output logic      bus_pullup_release_o,
    // switches
    input  wire logic [2:0] switch_overheat_i,
    input  wire logic pwm_i,
    output logic      switch_out_1_o,
    output logic      switch_out_2_o,
    output logic      switch_out_3_o,
    // regulator and supply
    input  wire logic regulator_heat_warning_i,
    input  wire logic regulator_overheat_i,
    input  wire logic high_volt_i,
    input  wire logic low_volt_i,
    input  wire logic [1:0] wake_pin_i,
    output logic      regulator_off_o,
    // watchdog and system
    input  wire logic wdog_period_config_open_i,
    input  wire logic wdog_period_config_gnd_i,
    output logic      dev_reset_o,
    output logic      irq_o,
    output logic [2:0] op_state_o
);
    typedef enum logic [4:0] {
        RDC_NREQ  = 5'h01,
        RDC_RUN   = 5'h02,
        RDC_STOP  = 5'h04,
        RDC_SLEEP = 5'h08,
        RDC_RESET = 5'h10
    } rdc_state_t;

    localparam int WDW = 32;

    // synchronised async inputs: txd, txd_oe, bus, fault, 3 heat, reg warn, reg hot, hv, lv, pwm, cfg x2, 2 wake
    localparam int NS = 16;
    // reset to idle pin levels: bus recessive, so rxd shows no false dominant
    localparam logic [NS-1:0] SYNC_IDLE = 16'h0004;
    logic [NS-1:0] in_raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic txd_s, txd_oe_s, bus_s, fault_s, reg_warn_s, reg_hot_s, hv_s, lv_s, pwm_s, cfg_open_s, cfg_gnd_s;
    logic [2:0] heat_s;
    logic [1:0] wake_s;
    logic [WDW-1:0] wd_period;

    rdc_state_t state_q;
    logic [7:0] ctl_q;
    logic [7:0] last_cmd_q;
    logic       cmd_armed_q;
    logic       sw_latch_q;
    logic       bus_flag_q;
    logic       reg_warn_flag_q;
    logic       intsrc_q;
    logic [WDW-1:0] wd_cnt_q;
    logic [7:0] status;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       frame_start;
    logic       wake;
    logic       low_power;
    logic       wd_en;
    logic       wd_clear;
    logic       wd_fail;
    logic       lp_cmd;
    logic       txd_eff;

    assign in_raw = {wake_pin_i, wdog_period_config_open_i, wdog_period_config_gnd_i, pwm_i, low_volt_i,
                     high_volt_i, regulator_overheat_i, regulator_heat_warning_i, switch_overheat_i,
                     lin_fault_i, lin_bus_i, txd_oe_i, txd_i};

    // two flip-flop synchronisers, one per asynchronous input bit
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q[gi] <= SYNC_IDLE[gi];
                    s2_q[gi] <= SYNC_IDLE[gi];
                end else begin
                    s1_q[gi] <= in_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    assign {wake_s, cfg_open_s, cfg_gnd_s, pwm_s, lv_s, hv_s, reg_hot_s, reg_warn_s, heat_s,
            fault_s, bus_s, txd_oe_s, txd_s} = s2_q;

    // undriven transmit input reads as high
    assign txd_eff   = txd_oe_s ? txd_s : 1'b1;
    assign low_power = (state_q == RDC_STOP) || (state_q == RDC_SLEEP);

    // status byte: interrupt marker, bus flag, supply, heat and wake pins
    assign status = {intsrc_q, bus_flag_q, hv_s, lv_s, reg_warn_flag_q, sw_latch_q, wake_s};

    rdc_spi_slave u_spi (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .sel_n_i           (sel_n_i),
        .serial_clock_in_i (serial_clock_in_i),
        .mosi_i            (mosi_i),
        .miso_o            (miso_o),
        .miso_oe_o         (miso_oe_o),
        .status_i          (status),
        .rx_byte_o         (rx_byte),
        .rx_valid_o        (rx_valid),
        .frame_start_o     (frame_start)
    );

    rdc_wake_filter u_wake (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .arm_i       (low_power),
        .bus_level_i (bus_s),
        .wake_o      (wake)
    );

    // a low-power command has slew bits 11 and all switch bits clear
    assign lp_cmd = rx_byte[rdc_pkg::CTL_SLEW_HI:rdc_pkg::CTL_SLEW_LO] == rdc_pkg::SLEW_LOWPOWER
                    && rx_byte[rdc_pkg::CTL_SW3:rdc_pkg::CTL_SW1] == 3'h0
                    && !rx_byte[rdc_pkg::CTL_OP_HI];
    assign wd_en    = !cfg_gnd_s;
    // an open config pin selects the default period, otherwise the resistor-set one
    assign wd_period = cfg_open_s ? WDW'(rdc_pkg::WD_TIMEOUT_CYC) : WDW'(WD_PERIOD_CYC);
    assign wd_clear = rx_valid && rx_byte[rdc_pkg::CTL_OP_HI:rdc_pkg::CTL_OP_LO] == rdc_pkg::OP_WD_CLEAR;
    // closed window is the first half of the period; open window the second half
    assign wd_fail  = wd_en && (
        (state_q == RDC_RUN && wd_clear && wd_cnt_q < (wd_period >> 1)) ||
        (state_q == RDC_RUN && wd_cnt_q >= wd_period - WDW'(1)) ||
        (state_q == RDC_NREQ && !wd_clear && wd_cnt_q >= WDW'(WD_NREQ_CYC - 1)));

    // control register commit and double low-power command check
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == RDC_RESET) begin
            ctl_q       <= rdc_pkg::CTL_RESET;
            last_cmd_q  <= 8'h00;
            cmd_armed_q <= 1'b0;
        end else if (rx_valid) begin
            last_cmd_q  <= rx_byte;
            cmd_armed_q <= lp_cmd;
            // a low-power byte leaves slew unchanged; only pull-up release and switch bits are written
            if (lp_cmd) begin
                ctl_q[rdc_pkg::CTL_PU_REL] <= rx_byte[rdc_pkg::CTL_PU_REL];
                ctl_q[rdc_pkg::CTL_SW3:rdc_pkg::CTL_SW1] <= 3'h0;
            end else begin
                ctl_q <= rx_byte;
            end
        end
    end

    // operating state machine and watchdog counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= RDC_RESET;
            wd_cnt_q <= '0;
        end else begin
            case (state_q)
                RDC_RESET: begin
                    state_q  <= RDC_NREQ;
                    wd_cnt_q <= '0;
                end
                RDC_NREQ, RDC_RUN: begin
                    if (wd_fail) begin
                        state_q <= RDC_RESET;
                    end else if (rx_valid && lp_cmd && cmd_armed_q && last_cmd_q == rx_byte) begin
                        state_q <= rx_byte[rdc_pkg::CTL_OP_LO] ? RDC_STOP : RDC_SLEEP;
                    end else if (wd_clear) begin
                        state_q  <= RDC_RUN;
                        wd_cnt_q <= '0;
                    end else begin
                        wd_cnt_q <= wd_cnt_q + 1'b1;
                    end
                end
                RDC_STOP: begin
                    wd_cnt_q <= '0;
                    if (wake || (frame_start)) begin
                        state_q <= RDC_NREQ;
                    end
                end
                RDC_SLEEP: begin
                    wd_cnt_q <= '0;
                    if (wake) begin
                        state_q <= RDC_RESET;
                    end
                end
                default: begin
                    state_q <= RDC_RESET;
                end
            endcase
        end
    end

    // flags: set wins over read-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_latch_q      <= 1'b0;
            bus_flag_q      <= 1'b0;
            reg_warn_flag_q <= 1'b0;
            intsrc_q        <= 1'b0;
        end else begin
            if (!low_power && |heat_s) begin
                sw_latch_q <= 1'b1;
            end else if (frame_start && sw_latch_q) begin
                sw_latch_q <= 1'b0;
            end
            if ((!low_power && fault_s) || wake) begin
                bus_flag_q <= 1'b1;
            end else if (frame_start && bus_flag_q) begin
                bus_flag_q <= 1'b0;
            end
            if (!low_power && reg_warn_s) begin
                reg_warn_flag_q <= 1'b1;
            end else if (frame_start) begin
                reg_warn_flag_q <= 1'b0;
            end
            if (wake || (!low_power && (reg_warn_s || |heat_s || hv_s || lv_s || fault_s))) begin
                intsrc_q <= 1'b1;
            end else if (frame_start) begin
                intsrc_q <= 1'b0;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lin_tx_en_o          <= 1'b0;
            lin_drive_dom_o      <= 1'b0;
            rxd_o                <= 1'b1;
            bus_slew_select_o    <= rdc_pkg::SLEW_RESET;
            bus_pullup_release_o <= 1'b0;
            switch_out_1_o       <= 1'b0;
            switch_out_2_o       <= 1'b0;
            switch_out_3_o       <= 1'b0;
            regulator_off_o      <= 1'b0;
            dev_reset_o          <= 1'b1;
            irq_o                <= 1'b0;
            op_state_o           <= 3'h0;
        end else begin
            lin_tx_en_o <= (state_q == RDC_RUN || state_q == RDC_NREQ) && !fault_s && !bus_flag_q;
            lin_drive_dom_o <= lin_tx_en_o && !txd_eff;
            rxd_o <= bus_s;
            bus_slew_select_o <= ctl_q[rdc_pkg::CTL_SLEW_HI:rdc_pkg::CTL_SLEW_LO];
            bus_pullup_release_o <= low_power && ctl_q[rdc_pkg::CTL_PU_REL];
            switch_out_1_o <= !low_power && !sw_latch_q && ctl_q[rdc_pkg::CTL_SW1] && pwm_s;
            switch_out_2_o <= !low_power && !sw_latch_q && ctl_q[rdc_pkg::CTL_SW2] && pwm_s;
            switch_out_3_o <= !low_power && !sw_latch_q && ctl_q[rdc_pkg::CTL_SW3];
            if (!low_power && reg_hot_s && reg_warn_flag_q) begin
                regulator_off_o <= 1'b1;
            end else if (state_q == RDC_RESET) begin
                regulator_off_o <= 1'b0;
            end
            dev_reset_o <= state_q == RDC_RESET || state_q == RDC_SLEEP;
            irq_o <= (!low_power && reg_warn_s && !reg_warn_flag_q) || (state_q == RDC_STOP && wake);
            op_state_o <= {low_power, state_q == RDC_SLEEP, state_q == RDC_RUN};
        end
    end
endmodule

// [rdc_control_properties.sv]
// Purpose: port checks of rdc_control
// Assumes: a few cycles cover input sync
// Notes:   up_q hides reset-time values
`timescale 1ns/1ns
module rdc_control_chk (
    // clock, reset and inputs
    input wire logic       clk_i, rst_i, sel_n_i, lin_fault_i,
    input wire logic [2:0] switch_overheat_i,
    // outputs
    input wire logic       miso_oe_o, lin_tx_en_o, bus_pullup_release_o, dev_reset_o,
    input wire logic       switch_out_1_o, switch_out_2_o, switch_out_3_o,
    input wire logic [2:0] op_state_o
);
    logic [3:0] up_q;
    logic       off, lp;
    // all switches off; low-power state
    assign off = !(switch_out_1_o | switch_out_2_o | switch_out_3_o);
    assign lp  = op_state_o[2];
    // cycles since reset, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_hot; (|switch_overheat_i) [*6]; endsequence
    sequence s_sel(v); (up_q == 4'hF && sel_n_i == v) [*6]; endsequence
    AST_HOT: assert property (s_hot |-> off) else $error("hot on");
    AST_LATCH: assert property (s_hot ##1 sel_n_i [*8] |-> off) else $error("no latch");
    AST_LP_SW: assert property (lp [*3] |-> off) else $error("lp on");
    AST_LP_TX: assert property (lp [*3] |-> !lin_tx_en_o) else $error("lp tx");
    AST_FAULT: assert property (lin_fault_i [*6] |-> !lin_tx_en_o) else $error("fault tx");
    AST_PU: assert property (!lp [*3] |-> !bus_pullup_release_o) else $error("pu off");
    AST_DESEL: assert property (s_sel(1'b1) |-> !miso_oe_o) else $error("miso on");
    AST_SEL: assert property (s_sel(1'b0) |-> miso_oe_o || dev_reset_o) else $error("miso off");
endmodule
bind rdc_control rdc_control_chk u_chk (.clk_i, .rst_i, .sel_n_i, .lin_fault_i, .switch_overheat_i,
    .miso_oe_o, .lin_tx_en_o, .bus_pullup_release_o, .dev_reset_o, .switch_out_1_o,
    .switch_out_2_o, .switch_out_3_o, .op_state_o);

// [rdc_spi_master.sv]
// Purpose: master side of the byte link
// Assumes: 160 ns serial clock
// Notes:   bits other than 8 is a framing fault
`timescale 1ns/1ns
module rdc_spi_master (
    // clock and answer
    input  wire logic clk_i, miso_i, miso_oe_i,
    // frame pins, clock still between frames
    output logic      sel_n_o, sck_o, mosi_o
);
    // idle at time zero
    initial {sel_n_o, sck_o, mosi_o} = 3'h4;
    // half a serial period, on falling clk_i
    task automatic half();
        repeat (8) @(negedge clk_i);
    endtask
    // msb first, shift on rise, sample on fall
    task automatic xfer(input logic [7:0] tx, input int bits, output logic [7:0] rx);
        rx = 8'h00;
        sel_n_o = 1'b0;
        half();
        for (int i = 0; i < bits; i++) begin
            {sck_o, mosi_o} = {1'b1, tx[7 - i]};
            half();
            sck_o = 1'b0;
            rx = {rx[6:0], miso_oe_i ? miso_i : 1'bx};
            half();
        end
        sel_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not look held
        half();
    endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench of rdc_control
// Assumes: short watchdog period
// Notes:   ctl_m models the control byte
`timescale 1ns/1ns
module tb_top;
    localparam int WD = 2000;
    logic clk_i = 1'b0, rst_i = 1'b1, sel_n_i, serial_clock_in_i, mosi_i, miso_o, miso_oe_o;
    logic txd_i, txd_oe_i, lin_bus_i, lin_fault_i, lin_drive_dom_o, rxd_o, lin_tx_en_o, irq_o;
    logic bus_pullup_release_o, pwm_i, switch_out_1_o, switch_out_2_o, switch_out_3_o;
    logic regulator_heat_warning_i, regulator_overheat_i, high_volt_i, low_volt_i, regulator_off_o;
    logic wdog_period_config_open_i, wdog_period_config_gnd_i, dev_reset_o;
    logic [1:0] bus_slew_select_o, wake_pin_i;
    logic [2:0] switch_overheat_i, op_state_o;
    logic [7:0] rx;
    int err_total = 0, checked = 0, n, ctl_m, n_rst = 0, m;
    integer seed = 32'h832a817e;
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    // reset cycles seen, so a short pulse inside a frame is not missed
    always @(negedge clk_i) if (dev_reset_o === 1'b1) n_rst++;
    rdc_control #(.WD_PERIOD_CYC(WD), .WD_NREQ_CYC(WD)) rdc_control_inst (.clk_i, .rst_i, .sel_n_i,
        .serial_clock_in_i, .mosi_i, .miso_o, .miso_oe_o, .txd_i, .txd_oe_i, .lin_bus_i, .lin_fault_i,
        .lin_drive_dom_o, .rxd_o, .lin_tx_en_o, .bus_slew_select_o, .bus_pullup_release_o,
        .switch_overheat_i, .pwm_i, .switch_out_1_o, .switch_out_2_o, .switch_out_3_o,
        .regulator_heat_warning_i, .regulator_overheat_i, .high_volt_i, .low_volt_i, .wake_pin_i,
        .regulator_off_o, .wdog_period_config_open_i, .wdog_period_config_gnd_i, .dev_reset_o,
        .irq_o, .op_state_o);
    rdc_spi_master mst (.clk_i, .miso_i(miso_o), .miso_oe_i(miso_oe_o), .sel_n_o(sel_n_i),
        .sck_o(serial_clock_in_i), .mosi_o(mosi_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a short frame leaves the model alone
    task automatic spi(input int b, input int bits = 8);
        mst.xfer(8'(b), bits, rx);
        if (bits == 8) ctl_m = b;
        repeat (6) @(negedge clk_i);
    endtask
    task automatic wait_rst(input logic v, input int lim);
        for (n = 0; dev_reset_o !== v && n < lim; n++) @(negedge clk_i);
        chk(8'(dev_reset_o), 8'(v));
    endtask
    task automatic chk_out();
        logic [7:0] e;
        e = 8'({ctl_m[7:6], ctl_m[4], ctl_m[3:2] & {2{pwm_i}}});
        chk(8'({bus_slew_select_o, switch_out_3_o, switch_out_2_o, switch_out_1_o}), e);
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {txd_i, txd_oe_i, lin_bus_i, pwm_i, wdog_period_config_gnd_i} = 5'h1F;
        {lin_fault_i, wdog_period_config_open_i, wake_pin_i, switch_overheat_i} = 7'h00;
        {regulator_heat_warning_i, regulator_overheat_i, high_volt_i, low_volt_i} = 4'h0;
        ctl_m = rdc_pkg::CTL_RESET;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_i);
        chk_out();
        for (int s = 0; s < 3; s++) begin
            {wake_pin_i, pwm_i} = 3'($random(seed));
            spi({s[1:0], 1'b0, 3'($random(seed)), rdc_pkg::OP_RUN});
            chk_out();
            chk(rx & 8'h03, 8'(wake_pin_i));
        end
        spi(8'h9F, 7);
        chk_out();
        $display("slew test done");
        for (int k = 0; k < 4; k++) begin
            {txd_oe_i, txd_i, lin_bus_i} = {2'(k), k[0]};
            repeat (6) @(negedge clk_i);
            chk(8'({lin_drive_dom_o, rxd_o}), 8'({txd_oe_i & !txd_i, lin_bus_i}));
        end
        lin_fault_i = 1'b1;
        repeat (6) @(negedge clk_i);
        lin_fault_i = 1'b0;
        repeat (6) @(negedge clk_i);
        chk(8'(lin_tx_en_o), 8'h00);
        spi(8'h03);
        chk(8'({rx[6], lin_tx_en_o}), 8'h03);
        $display("lin test done");
        pwm_i = 1'b1;
        spi(8'h1F);
        switch_overheat_i = 3'($random(seed)) | 3'h1;
        repeat (8) @(negedge clk_i);
        switch_overheat_i = 3'h0;
        repeat (8) @(negedge clk_i);
        chk(8'({switch_out_3_o, switch_out_2_o, switch_out_1_o}), 8'h00);
        spi(8'h1F);
        chk(8'(rx[2]), 8'h01);
        {regulator_heat_warning_i, regulator_overheat_i} = 2'h3;
        repeat (8) @(negedge clk_i);
        {regulator_heat_warning_i, regulator_overheat_i} = 2'h0;
        chk(8'(regulator_off_o), 8'h01);
        spi(8'hE1);
        chk(8'(op_state_o[2]), 8'h00);
        spi(8'hE1);
        chk(8'({op_state_o[2], bus_pullup_release_o, lin_tx_en_o}), 8'h06);
        lin_bus_i = 1'b0;
        repeat (rdc_pkg::WAKE_FILTER_CYC + 20) @(negedge clk_i);
        lin_bus_i = 1'b1;
        for (n = 0; irq_o !== 1'b1 && n < 50; n++) @(negedge clk_i);
        chk(8'(irq_o), 8'h01);
        chk(8'(dev_reset_o), 8'h00);
        $display("heat and stop test done");
        {wdog_period_config_gnd_i, wdog_period_config_open_i} = 2'h0;
        rst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        wait_rst(1'b0, 20);
        m = n_rst;
        spi(8'h02);
        chk(8'(n_rst - m), 8'h00);
        spi(8'h02);
        chk(8'(n_rst - m > 0), 8'h01);
        wait_rst(1'b0, 4 * WD);
        wait_rst(1'b1, WD + 100);
        spi(8'h02);
        repeat (WD * 3 / 5) @(negedge clk_i);
        m = n_rst;
        spi(8'h02);
        chk(8'(n_rst - m), 8'h00);
        wait_rst(1'b1, WD + 100);
        $display("watchdog test done");
        tally_and_finish();
    end
endmodule
